// ---- hdl/eag_core.sv ----
`timescale 1ns/1ns

module eag_core
(
    input wire logic core_clk, // Core clock, 100 MHz
    input wire logic rst, // Async reset, active high
    input wire logic start, // Begin address formation, one cycle
    input wire logic [15:0] pcIn, // Address of the opcode
    input wire eag_pkg::eag_mode_t modeIn, // Mode decoded from opcode
    input wire logic [7:0] prebyte, // Prefix byte, 00 when absent
    input wire logic [eag_pkg::ID_WIDTH-1:0] instrId, // Instruction id
    input wire logic [7:0] idxPrimary, // Primary index register
    input wire logic [7:0] idxSecondary, // Secondary index register
    input wire logic memAck, // Read data valid this cycle
    input wire logic [7:0] memRdata, // Read data from memory
    output logic memReqQ, // Read request, held until ack
    output logic [15:0] memAddrQ, // Read address
    output logic busyQ, // Sequence in progress
    output logic doneQ, // Result valid, one cycle
    output logic errQ, // Form not allowed for the instruction
    output logic [15:0] effAddrQ, // Effective operand address
    output logic [15:0] targetQ, // Next or branch program counter
    output logic [1:0] lenQ, // Bytes after the opcode
    output logic [eag_pkg::GROUP_WIDTH-1:0] groupQ // Instruction group
);
    import eag_pkg::*;

    eag_state_t stateQ, stateD;
    eag_mode_t modeQ, modeD;
    logic [15:0] pcQ, pcD;
    logic [7:0] idxQ, idxD;
    logic [7:0] op1Q, op1D, op2Q, op2D;
    logic [7:0] ptrHiQ, ptrHiD, ptrLoQ, ptrLoD;
    logic memReqD, busyD, doneD, errD;
    logic [15:0] memAddrD, effAddrD, targetD;
    logic [1:0] lenD;
    logic [GROUP_WIDTH-1:0] groupD, groupId;
    logic shortOnly, longOk, relOk, validId;
    eag_mode_t resMode;
    logic resUseY, resErr;

    function automatic logic isLong(eag_mode_t m);
        return m inside {M_DIR_L, M_IDX_L, M_IND_L, M_IIDX_L};
    endfunction

    function automatic logic isIndirect(eag_mode_t m);
        return m inside {M_IND_S, M_IND_L, M_IIDX_S, M_IIDX_L,
                         M_REL_I, M_BIT_I};
    endfunction

    function automatic logic isMemory(eag_mode_t m);
        return !(m inside {M_INH, M_IMM, M_REL_D, M_REL_I});
    endfunction

    function automatic logic [15:0] sext(logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction

    eag_instr_class uClass
    (
        .instrId(instrId),
        .groupId(groupId),
        .shortOnly(shortOnly),
        .longOk(longOk),
        .relOk(relOk),
        .validId(validId)
    );

    // Prefix resolution and legality of the requested form
    always_comb
    begin
        resMode = modeIn;
        resUseY = 1'b0;
        resErr = !validId;
        case (prebyte)
            PRE_NONE:
            begin
                resUseY = 1'b0;
            end
            PRE_SECOND:
            begin
                resUseY = 1'b1;
                if (isIndirect(modeIn))
                begin
                    resErr = 1'b1;
                end
            end
            PRE_INDIRECT:
            begin
                case (modeIn)
                    M_DIR_S: resMode = M_IND_S;
                    M_DIR_L: resMode = M_IND_L;
                    M_IDX_S: resMode = M_IIDX_S;
                    M_IDX_L: resMode = M_IIDX_L;
                    M_REL_D: resMode = M_REL_I;
                    M_BIT_D: resMode = M_BIT_I;
                    default: resErr = 1'b1;
                endcase
            end
            PRE_SEC_INDIRECT:
            begin
                resUseY = 1'b1;
                case (modeIn)
                    M_IDX_S, M_IIDX_S: resMode = M_IIDX_S;
                    M_IDX_L, M_IIDX_L: resMode = M_IIDX_L;
                    default: resErr = 1'b1;
                endcase
            end
            default:
            begin
                resErr = 1'b1;
            end
        endcase
        // Memory forms only for classes that take them
        if (isMemory(resMode) && !(longOk || shortOnly))
        begin
            resErr = 1'b1;
        end
        if (isLong(resMode) && shortOnly)
        begin
            resErr = 1'b1;
        end
        if ((resMode inside {M_REL_D, M_REL_I}) != relOk)
        begin
            resErr = 1'b1;
        end
    end

    always_comb
    begin
        stateD = stateQ;
        modeD = modeQ;
        pcD = pcQ;
        idxD = idxQ;
        op1D = op1Q;
        op2D = op2Q;
        ptrHiD = ptrHiQ;
        ptrLoD = ptrLoQ;
        memReqD = memReqQ;
        memAddrD = memAddrQ;
        busyD = busyQ;
        doneD = 1'b0;
        errD = errQ;
        effAddrD = effAddrQ;
        targetD = targetQ;
        lenD = lenQ;
        groupD = groupQ;
        case (stateQ)
            ST_IDLE:
            begin
                if (start)
                begin
                    pcD = pcIn;
                    modeD = resMode;
                    idxD = resUseY ? idxSecondary : idxPrimary;
                    errD = resErr;
                    groupD = groupId;
                    op1D = RST_BYTE;
                    op2D = RST_BYTE;
                    ptrHiD = PAGE_ZERO;
                    ptrLoD = RST_BYTE;
                    busyD = 1'b1;
                    // Nothing is fetched for these; an immediate byte is addressed, not read
                    if (resErr || resMode inside {M_INH, M_IMM, M_IDX_N})
                    begin
                        stateD = ST_DONE;
                    end
                    else
                    begin
                        stateD = ST_FETCH1;
                        memReqD = 1'b1;
                        memAddrD = pcIn + ADDR_STEP;
                    end
                end
            end
            ST_FETCH1:
            begin
                if (memAck)
                begin
                    op1D = memRdata;
                    if (modeQ inside {M_DIR_L, M_IDX_L})
                    begin
                        stateD = ST_FETCH2;
                        memAddrD = pcQ + ADDR_STEP + ADDR_STEP;
                    end
                    else if (isIndirect(modeQ))
                    begin
                        stateD = ST_PTR1;
                        memAddrD = {PAGE_ZERO, memRdata};
                    end
                    else
                    begin
                        stateD = ST_DONE;
                        memReqD = 1'b0;
                    end
                end
            end
            ST_FETCH2:
            begin
                if (memAck)
                begin
                    op2D = memRdata;
                    stateD = ST_DONE;
                    memReqD = 1'b0;
                end
            end
            ST_PTR1:
            begin
                if (memAck)
                begin
                    if (modeQ inside {M_IND_L, M_IIDX_L})
                    begin
                        ptrHiD = memRdata;
                        stateD = ST_PTR2;
                        // Pointer stays in page zero, wraps at FF
                        memAddrD = {PAGE_ZERO, memAddrQ[7:0] + 8'h01};
                    end
                    else
                    begin
                        ptrLoD = memRdata;
                        stateD = ST_DONE;
                        memReqD = 1'b0;
                    end
                end
            end
            ST_PTR2:
            begin
                if (memAck)
                begin
                    ptrLoD = memRdata;
                    stateD = ST_DONE;
                    memReqD = 1'b0;
                end
            end
            ST_DONE:
            begin
                stateD = ST_IDLE;
                busyD = 1'b0;
                doneD = 1'b1;
                lenD = RST_LEN;
                effAddrD = RST_ADDR;
                case (modeQ)
                    M_IMM:
                    begin
                        effAddrD = pcQ + ADDR_STEP;
                        lenD = 2'h1;
                    end
                    M_DIR_S, M_BIT_D:
                    begin
                        effAddrD = {PAGE_ZERO, op1Q};
                        lenD = 2'h1;
                    end
                    M_DIR_L:
                    begin
                        effAddrD = {op1Q, op2Q};
                        lenD = 2'h2;
                    end
                    M_IDX_N:
                    begin
                        effAddrD = {PAGE_ZERO, idxQ};
                    end
                    M_IDX_S:
                    begin
                        // Carry kept, so the top lands at 1FE
                        effAddrD = {7'h00, {1'b0, idxQ} + {1'b0, op1Q}};
                        lenD = 2'h1;
                    end
                    M_IDX_L:
                    begin
                        effAddrD = {op1Q, op2Q} + {PAGE_ZERO, idxQ};
                        lenD = 2'h2;
                    end
                    M_IND_S, M_BIT_I:
                    begin
                        effAddrD = {PAGE_ZERO, ptrLoQ};
                        lenD = 2'h1;
                    end
                    M_IND_L:
                    begin
                        effAddrD = {ptrHiQ, ptrLoQ};
                        lenD = 2'h1;
                    end
                    M_IIDX_S:
                    begin
                        effAddrD = {7'h00, {1'b0, idxQ} + {1'b0, ptrLoQ}};
                        lenD = 2'h1;
                    end
                    M_IIDX_L:
                    begin
                        effAddrD = {ptrHiQ, ptrLoQ} + {PAGE_ZERO, idxQ};
                        lenD = 2'h1;
                    end
                    M_REL_D, M_REL_I:
                    begin
                        lenD = 2'h1;
                    end
                    default:
                    begin
                        lenD = RST_LEN;
                    end
                endcase
                targetD = pcQ + ADDR_STEP + {14'h0000, lenD};
                if (!errQ && modeQ == M_REL_D)
                begin
                    targetD = pcQ + 16'h0002 + sext(op1Q);
                end
                else if (!errQ && modeQ == M_REL_I)
                begin
                    targetD = pcQ + 16'h0002 + sext(ptrLoQ);
                end
            end
            default:
            begin
                stateD = ST_IDLE;
                memReqD = 1'b0;
                busyD = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            stateQ <= ST_IDLE;
            modeQ <= M_INH;
            pcQ <= RST_ADDR;
            idxQ <= RST_BYTE;
            op1Q <= RST_BYTE;
            op2Q <= RST_BYTE;
            ptrHiQ <= RST_BYTE;
            ptrLoQ <= RST_BYTE;
            memReqQ <= 1'b0;
            memAddrQ <= RST_ADDR;
            busyQ <= 1'b0;
            doneQ <= 1'b0;
            errQ <= 1'b0;
            effAddrQ <= RST_ADDR;
            targetQ <= RST_ADDR;
            lenQ <= RST_LEN;
            groupQ <= '0;
        end
        else
        begin
            stateQ <= stateD;
            modeQ <= modeD;
            pcQ <= pcD;
            idxQ <= idxD;
            op1Q <= op1D;
            op2Q <= op2D;
            ptrHiQ <= ptrHiD;
            ptrLoQ <= ptrLoD;
            memReqQ <= memReqD;
            memAddrQ <= memAddrD;
            busyQ <= busyD;
            doneQ <= doneD;
            errQ <= errD;
            effAddrQ <= effAddrD;
            targetQ <= targetD;
            lenQ <= lenD;
            groupQ <= groupD;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_idx_none_nofetch: assert property (
        start && !busyQ && !resErr && resMode == M_IDX_N
        |=> !memReqQ ##1 (doneQ && lenQ == 2'h0
            && effAddrQ[15:8] == 8'h00))
        else $error("no-offset indexed fetched or left page zero");

    a_idx_short_range: assert property (
        doneQ && modeQ == M_IDX_S
        |-> effAddrQ <= SHORT_IDX_MAX && lenQ == 2'h1
            && effAddrQ == 16'(idxQ) + 16'(op1Q))
        else $error("short indexed sum wrong");

    a_long_two_fetch: assert property (
        stateQ == ST_FETCH1 && memAck && modeQ inside {M_DIR_L, M_IDX_L}
        |=> stateQ == ST_FETCH2 && memReqQ
            && memAddrQ == pcQ + 16'h0002)
        else $error("long offset second byte not fetched");

    a_ind_ptr_fetch: assert property (
        stateQ == ST_FETCH1 && memAck && isIndirect(modeQ)
        |=> memReqQ && memAddrQ == {8'h00, $past(memRdata)})
        else $error("pointer not read at pointer address");

    a_ptr_byte_order: assert property (
        stateQ == ST_PTR1 && memAck && modeQ inside {M_IND_L, M_IIDX_L}
        |=> stateQ == ST_PTR2 && ptrHiQ == $past(memRdata)
            && memAddrQ[7:0] == $past(memAddrQ[7:0]) + 8'h01)
        else $error("pointer high byte not read first");

    a_short_only_err: assert property (
        start && !busyQ && shortOnly && validId && prebyte == PRE_NONE
        && isLong(modeIn)
        |-> ##2 (doneQ && errQ))
        else $error("long form accepted for short-only class");

    a_rel_span: assert property (
        doneQ && !errQ && modeQ inside {M_REL_D, M_REL_I}
        |-> 16'(targetQ - pcQ - 16'h0002) inside
            {[16'h0000:16'h007F], [16'hFF80:16'hFFFF]})
        else $error("relative target outside signed byte reach");

    a_rel_indirect: assert property (
        stateQ == ST_FETCH1 && memAck && modeQ == M_REL_I
        |=> stateQ == ST_PTR1 ##[1:1000] doneQ)
        else $error("relative indirect offset not read");

    a_prefix_swap: assert property (
        start && !busyQ && prebyte == PRE_SECOND
        |=> idxQ == $past(idxSecondary))
        else $error("secondary prefix did not select secondary index");

    // A start in the done cycle is legal and raises busy right after
    a_done_pulse: assert property (
        doneQ |=> !doneQ && (!busyQ || $past(start)))
        else $error("done held longer than one cycle");

    c_idx_long: cover property (doneQ && !errQ && modeQ == M_IDX_L);
    c_iidx_long: cover property (doneQ && !errQ && modeQ == M_IIDX_L);
    c_rel_ind: cover property (doneQ && !errQ && modeQ == M_REL_I);
    c_error: cover property (doneQ && errQ);

endmodule

// ---- hdl/eag_pkg.sv ----
`timescale 1ns/1ns

package eag_pkg;

    // Prefix bytes ahead of the opcode
    localparam logic [7:0] PRE_NONE = 8'h00;
    localparam logic [7:0] PRE_SECOND = 8'h90;
    localparam logic [7:0] PRE_INDIRECT = 8'h92;
    localparam logic [7:0] PRE_SEC_INDIRECT = 8'h91;

    localparam int INSTR_COUNT = 63;
    localparam int GROUP_COUNT = 13;
    localparam int ID_WIDTH = 6;
    localparam int GROUP_WIDTH = 4;

    // First instruction id of each functional group
    localparam logic [5:0] GROUP_START [GROUP_COUNT] = '{
        6'h00, 6'h02, 6'h05, 6'h07, 6'h0A, 6'h0F, 6'h11,
        6'h13, 6'h18, 6'h1F, 6'h27, 6'h37, 6'h3B
    };

    // Per-id capability masks, bit n belongs to instruction id n
    localparam logic [63:0] MASK_SHORT_ONLY = 64'h0000_000C_3F07_E162;
    localparam logic [63:0] MASK_LONG_OK = 64'h0000_0000_0078_1E81;
    localparam logic [63:0] MASK_RELATIVE = 64'h007F_FF93_8000_0000;

    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [15:0] ADDR_STEP = 16'h0001;
    localparam logic [15:0] SHORT_IDX_MAX = 16'h01FE;
    localparam logic [1:0] RST_LEN = 2'h0;

    typedef enum logic [3:0] {
        M_INH = 4'b0000,
        M_IMM = 4'b0001,
        M_DIR_S = 4'b0010,
        M_DIR_L = 4'b0011,
        M_IDX_N = 4'b0100,
        M_IDX_S = 4'b0101,
        M_IDX_L = 4'b0110,
        M_IND_S = 4'b0111,
        M_IND_L = 4'b1000,
        M_IIDX_S = 4'b1001,
        M_IIDX_L = 4'b1010,
        M_REL_D = 4'b1011,
        M_REL_I = 4'b1100,
        M_BIT_D = 4'b1101,
        M_BIT_I = 4'b1110
    } eag_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH1 = 3'b001,
        ST_FETCH2 = 3'b010,
        ST_PTR1 = 3'b011,
        ST_PTR2 = 3'b100,
        ST_DONE = 3'b101
    } eag_state_t;

endpackage

module eag_instr_class
(
    input wire logic [eag_pkg::ID_WIDTH-1:0] instrId, // Instruction id
    output logic [eag_pkg::GROUP_WIDTH-1:0] groupId, // Functional group
    output logic shortOnly, // Short memory forms only
    output logic longOk, // Long and short forms allowed
    output logic relOk, // Must use relative modes
    output logic validId // Id is one of the set
);
    import eag_pkg::*;

    logic [GROUP_COUNT-1:0] atOrAbove;

    genvar g;
    generate
        for (g = 0; g < GROUP_COUNT; g++)
        begin : gGroup
            assign atOrAbove[g] = instrId >= GROUP_START[g];
        end
    endgenerate

    always_comb
    begin
        groupId = '0;
        for (int i = 1; i < GROUP_COUNT; i++)
        begin
            if (atOrAbove[i])
            begin
                groupId = GROUP_WIDTH'(i);
            end
        end
        validId = 32'(instrId) < INSTR_COUNT;
        shortOnly = MASK_SHORT_ONLY[instrId];
        longOk = MASK_LONG_OK[instrId];
        relOk = MASK_RELATIVE[instrId];
    end

endmodule

// ---- bench/eag_mem_model.sv ----
`timescale 1ns/1ns

module eag_mem_model
(
    input wire logic core_clk, // Core clock
    input wire logic memReqQ, // Read request
    input wire logic [15:0] memAddrQ, // Read address
    input wire logic [1:0] slowCycles, // Wait cycles before each ack
    output logic memAck, // Read data valid
    output logic [7:0] memRdata // Read data
);
    logic [7:0] memByte [0:65535];
    int waitCnt = 0;
    int rdCount = 0;

    initial
    begin
        memAck = 1'b0;
        memRdata = 8'h00;
    end

    always @(posedge core_clk)
    begin
        // Sampled before the design's flops move
        if (memAck && memReqQ)
            rdCount++;
        #1;
        // Waits counted per request, the first read included
        if (memReqQ && waitCnt >= slowCycles)
        begin
            memAck = 1'b1;
            memRdata = memByte[memAddrQ];
            waitCnt = 0;
        end
        else
        begin
            // Released bus must not look like stale valid data
            memAck = 1'b0;
            memRdata = ~memRdata;
            waitCnt = memReqQ ? waitCnt + 1 : 0;
        end
    end
endmodule

// ---- bench/effective_address_generator_tb.sv ----
`timescale 1ns/1ns

module effective_address_generator_tb;
    import eag_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [15:0] pcIn = 16'h0000;
    eag_mode_t modeIn = M_INH;
    logic [7:0] prebyte = 8'h00;
    logic [5:0] instrId = 6'h00;
    logic [7:0] ix = 8'h00;
    logic [7:0] iy = 8'h00;
    logic [1:0] slowCycles = 2'h0;
    logic memAck, memReqQ, busyQ, doneQ, errQ;
    logic [7:0] memRdata;
    logic [15:0] memAddrQ, effAddrQ, targetQ;
    logic [1:0] lenQ;
    logic [3:0] groupQ;
    int err_total = 0;
    int compares = 0;

    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    eag_core u_eag_core (.core_clk(core_clk), .rst(rst), .start(start),
        .pcIn(pcIn), .modeIn(modeIn), .prebyte(prebyte),
        .instrId(instrId), .idxPrimary(ix), .idxSecondary(iy),
        .memAck(memAck), .memRdata(memRdata), .memReqQ(memReqQ),
        .memAddrQ(memAddrQ), .busyQ(busyQ), .doneQ(doneQ), .errQ(errQ),
        .effAddrQ(effAddrQ), .targetQ(targetQ), .lenQ(lenQ),
        .groupQ(groupQ));

    eag_mem_model u_mem (.core_clk(core_clk), .memReqQ(memReqQ),
        .memAddrQ(memAddrQ), .slowCycles(slowCycles), .memAck(memAck),
        .memRdata(memRdata));

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("unexpected %s exp %h got %h", what, exp, got);
            err_total++;
        end
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One request, judged at the doneQ cycle; full=0 only waits
    task automatic runOp(logic [7:0] pre, eag_mode_t mode, logic [5:0] id,
        logic [15:0] pc, logic [15:0] eff, logic [15:0] tgt,
        logic [1:0] len, logic err, int reads, bit full = 1'b1);
        int n;
        int r0;
        r0 = u_mem.rdCount;
        prebyte = pre;
        modeIn = mode;
        instrId = id;
        pcIn = pc;
        start = 1'b1;
        @(posedge core_clk);
        #1;
        start = 1'b0;
        n = 0;
        while (doneQ !== 1'b1 && n < 40)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 40)
        begin
            check("doneQ", 16'h0001, {15'h0000, doneQ});
            report_and_stop();
        end
        if (full)
        begin
            check("errQ", {15'h0000, err}, {15'h0000, errQ});
            check("effAddrQ", eff, effAddrQ);
            check("reads", reads[15:0], 16'(u_mem.rdCount - r0));
            check("busyQ", 16'h0000, {15'h0000, busyQ});
            if (!err)
            begin
                check("targetQ", tgt, targetQ);
                check("lenQ", {14'h0000, len}, {14'h0000, lenQ});
            end
        end
    endtask

    task automatic t_reset;
        check("outputs after reset", 16'h0000, {memReqQ, busyQ, doneQ,
            errQ, lenQ, groupQ, 6'h00});
        check("effAddrQ after reset", 16'h0000, effAddrQ);
        check("memAddrQ after reset", 16'h0000, memAddrQ);
        check("targetQ after reset", 16'h0000, targetQ);
    endtask

    task automatic t_indexed;
        ix = 8'hFF;
        iy = 8'h12;
        runOp(8'h00, M_IDX_N, 6'h00, 16'h0200, 16'h00FF, 16'h0201, 2'h0,
            1'b0, 0);
        u_mem.memByte[16'h0301] = 8'hFF;
        runOp(8'h00, M_IDX_S, 6'h00, 16'h0300, 16'h01FE, 16'h0302, 2'h1,
            1'b0, 1);
        u_mem.memByte[16'h0401] = 8'hFE;
        runOp(8'h90, M_IDX_S, 6'h00, 16'h0400, 16'h0110, 16'h0402, 2'h1,
            1'b0, 1);
        u_mem.memByte[16'h0501] = 8'h12;
        u_mem.memByte[16'h0502] = 8'h34;
        runOp(8'h00, M_IDX_L, 6'h07, 16'h0500, 16'h1333, 16'h0503, 2'h2,
            1'b0, 2);
        runOp(8'h00, M_DIR_L, 6'h00, 16'h0500, 16'h1234, 16'h0503, 2'h2,
            1'b0, 2);
        runOp(8'h00, M_IMM, 6'h00, 16'h0E00, 16'h0E01, 16'h0E02, 2'h1,
            1'b0, 0);
        runOp(8'h90, M_IDX_N, 6'h00, 16'h0200, 16'h0012, 16'h0201, 2'h0,
            1'b0, 0);
    endtask

    task automatic t_indirect;
        u_mem.memByte[16'h0601] = 8'h40;
        u_mem.memByte[16'h0040] = 8'hA5;
        runOp(8'h92, M_DIR_S, 6'h00, 16'h0600, 16'h00A5, 16'h0602, 2'h1,
            1'b0, 2);
        // Pointer at page end wraps to 00 for its low byte
        u_mem.memByte[16'h0701] = 8'hFF;
        u_mem.memByte[16'h00FF] = 8'hBE;
        u_mem.memByte[16'h0000] = 8'hEF;
        runOp(8'h92, M_DIR_L, 6'h00, 16'h0700, 16'hBEEF, 16'h0702, 2'h1,
            1'b0, 3);
        slowCycles = 2'h1;
        u_mem.memByte[16'h0801] = 8'h50;
        u_mem.memByte[16'h0050] = 8'h80;
        u_mem.memByte[16'h0051] = 8'h00;
        runOp(8'h91, M_IDX_L, 6'h00, 16'h0800, 16'h8012, 16'h0802, 2'h1,
            1'b0, 3);
        slowCycles = 2'h0;
        u_mem.memByte[16'h0901] = 8'h60;
        u_mem.memByte[16'h0060] = 8'hFF;
        runOp(8'h92, M_IDX_S, 6'h00, 16'h0900, 16'h01FE, 16'h0902, 2'h1,
            1'b0, 2);
        runOp(8'h91, M_IIDX_S, 6'h00, 16'h0900, 16'h0111, 16'h0902, 2'h1,
            1'b0, 2);
        runOp(8'h00, M_BIT_D, 6'h0F, 16'h0600, 16'h0040, 16'h0602, 2'h1,
            1'b0, 1);
        runOp(8'h92, M_BIT_D, 6'h0F, 16'h0600, 16'h00A5, 16'h0602, 2'h1,
            1'b0, 2);
        runOp(8'h90, M_IND_S, 6'h00, 16'h0600, 16'h0000, 16'h0000, 2'h0,
            1'b1, 0);
        runOp(8'h55, M_DIR_S, 6'h00, 16'h0600, 16'h0000, 16'h0000, 2'h0,
            1'b1, 0);
        runOp(8'h91, M_DIR_S, 6'h00, 16'h0600, 16'h0000, 16'h0000, 2'h0,
            1'b1, 0);
    endtask

    task automatic t_relative;
        u_mem.memByte[16'h0A01] = 8'h80;
        runOp(8'h00, M_REL_D, 6'h1F, 16'h0A00, 16'h0000, 16'h0982, 2'h1,
            1'b0, 1);
        u_mem.memByte[16'h0B01] = 8'h70;
        u_mem.memByte[16'h0070] = 8'h7F;
        runOp(8'h92, M_REL_D, 6'h24, 16'h0B00, 16'h0000, 16'h0B81, 2'h1,
            1'b0, 2);
        runOp(8'h00, M_REL_D, 6'h00, 16'h0B00, 16'h0000, 16'h0000, 2'h0,
            1'b1, 0);
    endtask

    task automatic t_classes;
        logic [5:0] longIds [10] = '{0, 7, 9, 10, 11, 12, 19, 20, 21, 22};
        logic [5:0] shortIds [21] = '{1, 5, 6, 8, 13, 14, 15, 16, 17, 18,
            24, 25, 26, 27, 28, 29, 34, 35, 1, 5, 6};
        ix = 8'h00;
        u_mem.memByte[16'h0C01] = 8'h33;
        u_mem.memByte[16'h0C02] = 8'h10;
        foreach (longIds[i])
            runOp(8'h00, M_IDX_L, longIds[i], 16'h0C00, 16'h3310, 16'h0C03,
                2'h2, 1'b0, 2);
        foreach (shortIds[i])
        begin
            runOp(8'h00, M_IDX_L, shortIds[i], 16'h0C00, 16'h0000,
                16'h0000, 2'h0, 1'b1, 0);
            runOp(8'h00, M_DIR_S, shortIds[i], 16'h0C00, 16'h0033,
                16'h0C02, 2'h1, 1'b0, 1);
        end
    endtask

    task automatic t_groups;
        for (int g = 0; g < GROUP_COUNT; g++)
        begin
            runOp(8'h00, M_INH, GROUP_START[g], 16'h0D00, 16'h0000,
                16'h0000, 2'h0, 1'b0, 0, 1'b0);
            check("groupQ", 16'(g), {12'h000, groupQ});
        end
        runOp(8'h00, M_INH, 6'h3F, 16'h0D00, 16'h0000, 16'h0000, 2'h0,
            1'b1, 0);
    endtask

    initial
    begin
        repeat (3) @(posedge core_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_indexed();
        t_indirect();
        t_relative();
        t_classes();
        t_groups();
        report_and_stop();
    end
endmodule
